// [design/cdl_diag.sv]
// Channel diagnosis latches with APB register access and interrupt.
//
// Decided for this implementation: the register addresses and the APB slave port.
`timescale 1ns/1ps

// Behaviour
// - Latched protection flag per channel.
// - Clear-latch bit clears all protection flags.
// - Clear-latch bit self-clears after next frame.
// - Latched open-load flag per channel.
// - Reading diagnosis register clears open-load flags.
// - No open-load detection while channel on.
// - Open-load flag after 100 to 250 us.
// - Diagnosis current enable bit drives current.
// - Over temperature sets flag, forces off.
// - Over load switches off within 60 us.
// - Faulted channel stays off until cleared.
// - Over temperature flags even when off.
// - Flags readable only with bank select one.
module cdl_diag (
  input  wire logic             pclk,
  input  wire logic             presetn,
  input  wire logic [7:0]       paddr,
  input  wire logic             psel,
  input  wire logic             penable,
  input  wire logic             pwrite,
  input  wire logic [31:0]      pwdata,
  output logic      [31:0]      prdata,
  output logic                  pready,
  output logic                  pslverr,
  input  wire cdl_pkg::cdl_chan_t over_temp_in,
  input  wire cdl_pkg::cdl_chan_t over_load_in,
  input  wire cdl_pkg::cdl_chan_t open_load_level_in,
  output cdl_pkg::cdl_chan_t    channel_on,
  output cdl_pkg::cdl_chan_t    diag_current_enable,
  output logic                  irq
);
  import cdl_pkg::*;

  function automatic logic is_mapped(input logic [7:0] a);
    is_mapped = (a == ADDR_CTRL) || (a == ADDR_CHAN_ON) || (a == ADDR_DIAG_CUR) ||
                (a == ADDR_DIAG) || (a == ADDR_IRQ_STATUS) || (a == ADDR_IRQ_MASK) ||
                (a == ADDR_CHAN_STATE);
  endfunction : is_mapped

  ////////////////////////////////////////////////////////////////////////////////
  cdl_chan_t ot_s;
  cdl_chan_t ovl_s;
  cdl_chan_t ol_lvl_s;

  cdl_sync #(.W(NUM_CH)) u_sync_ot (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (over_temp_in),
    .sync_out (ot_s)
  );
  cdl_sync #(.W(NUM_CH)) u_sync_ovl (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (over_load_in),
    .sync_out (ovl_s)
  );
  cdl_sync #(.W(NUM_CH)) u_sync_ol (
    .pclk     (pclk),
    .presetn  (presetn),
    .async_in (open_load_level_in),
    .sync_out (ol_lvl_s)
  );

  ////////////////////////////////////////////////////////////////////////////////
  logic [6:0] tick_cnt;
  logic [6:0] next_tick_cnt;
  logic       tick;

  always_comb begin
    tick          = (tick_cnt == 7'(TICK_CYCLES - 1));
    next_tick_cnt = tick ? 7'h00 : tick_cnt + 7'h01;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      tick_cnt <= 7'h00;
    end else begin
      tick_cnt <= next_tick_cnt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  cdl_chan_t ol_arm;
  cdl_chan_t ol_qual;
  cdl_chan_t ol_qual_g;

  assign ol_arm    = ~channel_on & ol_lvl_s;
  assign ol_qual_g = ol_qual & ol_arm;

  for (genvar i = 0; i < NUM_CH; i++) begin : g_ol
    cdl_ol_timer u_timer (
      .pclk      (pclk),
      .presetn   (presetn),
      .tick      (tick),
      .arm       (ol_arm[i]),
      .qualified (ol_qual[i])
    );
  end

  ////////////////////////////////////////////////////////////////////////////////
  logic      clear_protection_latch;
  logic      bank;
  cdl_chan_t chan_req;
  cdl_chan_t prot_flag;
  cdl_chan_t ol_flag;
  cdl_chan_t ol_snap;
  logic [1:0] irq_status;
  logic [1:0] irq_mask;

  logic      next_clear_protection_latch;
  logic      next_bank;
  cdl_chan_t next_chan_req;
  cdl_chan_t next_diag_cur;
  cdl_chan_t next_prot_flag;
  cdl_chan_t next_ol_flag;
  cdl_chan_t next_ol_snap;
  cdl_chan_t next_channel_on;
  logic [1:0] next_irq_status;
  logic [1:0] next_irq_mask;
  logic       next_irq;
  logic [31:0] next_prdata;
  cdl_chan_t  new_prot;
  cdl_chan_t  ol_clr;
  logic       acc;
  logic       setup;
  logic       wr;
  logic       clear_write;

  assign pready  = 1'b1;
  assign acc     = psel & penable;
  assign setup   = psel & ~penable;
  assign wr      = acc & pwrite;
  assign pslverr = acc & ~is_mapped(paddr);
  assign clear_write = wr && (paddr == ADDR_CTRL) && pwdata[CTRL_CLEAR_BIT];
  assign ol_clr  = (acc && !pwrite && (paddr == ADDR_DIAG)) ? ol_snap : '0;

  always_comb begin
    next_bank     = bank;
    next_chan_req = chan_req;
    next_diag_cur = diag_current_enable;
    next_irq_mask = irq_mask;
    next_prdata   = prdata;
    next_ol_snap  = ol_snap;
    next_clear_protection_latch = (acc && is_mapped(paddr)) ? 1'b0 : clear_protection_latch;
    if (wr) begin
      case (paddr)
        ADDR_CTRL: begin
          next_clear_protection_latch = pwdata[CTRL_CLEAR_BIT];
          next_bank = pwdata[CTRL_BANK_BIT];
        end
        ADDR_CHAN_ON: begin
          next_chan_req = pwdata[NUM_CH-1:0];
        end
        ADDR_DIAG_CUR: begin
          next_diag_cur = pwdata[NUM_CH-1:0];
        end
        ADDR_IRQ_MASK: begin
          next_irq_mask = pwdata[1:0];
        end
        default: begin
        end
      endcase
    end
    if (setup && !pwrite) begin
      next_ol_snap = '0;
      case (paddr)
        ADDR_CTRL:       next_prdata = {30'h0, bank, clear_protection_latch};
        ADDR_CHAN_ON:    next_prdata = {24'h0, chan_req};
        ADDR_DIAG_CUR:   next_prdata = {24'h0, diag_current_enable};
        ADDR_IRQ_STATUS: next_prdata = {30'h0, irq_status};
        ADDR_IRQ_MASK:   next_prdata = {30'h0, irq_mask};
        ADDR_CHAN_STATE: next_prdata = {24'h0, channel_on};
        ADDR_DIAG: begin
          next_prdata  = bank ? {16'h0, ol_flag, prot_flag} : 32'h0;
          next_ol_snap = bank ? ol_flag : '0;
        end
        default:         next_prdata = 32'h0;
      endcase
    end
    // over temperature or load sets flag.
    new_prot = ot_s | ovl_s;
    next_prot_flag = (clear_write ? '0 : prot_flag) | new_prot;
    next_channel_on = next_chan_req & ~next_prot_flag;
    next_ol_flag = (ol_flag & ~ol_clr) | ol_qual_g;
    next_irq_status = irq_status;
    if (wr && (paddr == ADDR_IRQ_STATUS)) begin
      next_irq_status = irq_status & ~pwdata[1:0];
    end
    next_irq_status[IRQ_PROT_BIT] = next_irq_status[IRQ_PROT_BIT] | (|(new_prot & ~prot_flag));
    next_irq_status[IRQ_OL_BIT]   = next_irq_status[IRQ_OL_BIT] | (|(ol_qual_g & ~ol_flag));
    next_irq = |(next_irq_status & next_irq_mask);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      clear_protection_latch <= 1'b0;
      bank                <= 1'b0;
      chan_req            <= CHAN_ON_RST;
      diag_current_enable <= DIAG_CUR_RST;
      prot_flag           <= '0;
      ol_flag             <= '0;
      ol_snap             <= '0;
      channel_on          <= '0;
      irq_status          <= 2'h0;
      irq_mask            <= IRQ_MASK_RST;
      irq                 <= 1'b0;
      prdata              <= 32'h0;
    end else begin
      clear_protection_latch <= next_clear_protection_latch;
      bank                <= next_bank;
      chan_req            <= next_chan_req;
      diag_current_enable <= next_diag_cur;
      prot_flag           <= next_prot_flag;
      ol_flag             <= next_ol_flag;
      ol_snap             <= next_ol_snap;
      channel_on          <= next_channel_on;
      irq_status          <= next_irq_status;
      irq_mask            <= next_irq_mask;
      irq                 <= next_irq;
      prdata              <= next_prdata;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Helper: consecutive cycles that channel 4 has been armed for open load.
  logic [15:0] arm_run4;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      arm_run4 <= 16'h0000;
    end else if (!ol_arm[4]) begin
      arm_run4 <= 16'h0000;
    end else if (arm_run4 != 16'hffff) begin
      arm_run4 <= arm_run4 + 16'h0001;
    end
  end

  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);

  sequence s_clear_set;
    clear_write && ovl_s == '0 && ot_s == '0;
  endsequence

  sequence s_other_frame;
    acc && is_mapped(paddr) && !(wr && paddr == ADDR_CTRL);
  endsequence

  sequence s_ovl_held;
    (over_load_in != '0 && over_load_in == $past(over_load_in)) [*3];
  endsequence

  prot_latch_a: assert property ((prot_flag != '0 && !clear_write) |=>
    ((prot_flag & $past(prot_flag)) == $past(prot_flag)))
    else $error("protection flag lost without clear command");
  latch_clear_a: assert property (s_clear_set |=> prot_flag == '0)
    else $error("clear command left protection flags set");
  latch_self_a: assert property (clear_protection_latch ##0 s_other_frame |=>
    !clear_protection_latch)
    else $error("clear-latch bit did not self-clear");
  ol_hold_a: assert property (1'b1 |=>
    ((ol_flag & $past(ol_flag & ~ol_clr)) == $past(ol_flag & ~ol_clr)))
    else $error("open-load flag dropped without read");
  ol_read_a: assert property ((ol_clr != '0 && ol_qual_g == '0) |=>
    ((ol_flag & $past(ol_clr)) == '0))
    else $error("diagnosis read did not clear open-load flag");
  ol_on_a: assert property ((channel_on[0] && !ol_flag[0]) |=> !ol_flag[0])
    else $error("open-load flag set while channel on");
  ol_min_a: assert property ($rose(ol_flag[4]) |-> arm_run4 >= 16'(OPEN_LOAD_MIN_CYCLES))
    else $error("open-load flag set before minimum delay");
  ol_max_a: assert property ((arm_run4 >= 16'(OPEN_LOAD_MAX_CYCLES)) |-> ol_flag[4])
    else $error("open-load flag late beyond maximum delay");
  diag_cur_a: assert property ((wr && paddr == ADDR_DIAG_CUR) |=>
    diag_current_enable == $past(pwdata[NUM_CH-1:0]))
    else $error("diagnosis current enable not updated");
  ot_flag_a: assert property ((ot_s != '0) |=>
    ((prot_flag & $past(ot_s)) == $past(ot_s)) && ((channel_on & $past(ot_s)) == '0))
    else $error("over temperature did not flag and switch off");
  ovl_off_a: assert property (s_ovl_held |=>
    ((channel_on | ~prot_flag) & $past(over_load_in)) == '0)
    else $error("over load did not switch channel off in time");
  forced_off_a: assert property ((channel_on & prot_flag) == '0)
    else $error("faulted channel is on");
  ot_off_a: assert property (((ot_s & ~channel_on) != '0) |=>
    ((prot_flag & $past(ot_s & ~channel_on)) == $past(ot_s & ~channel_on)))
    else $error("over temperature in off state not flagged");
  bank_read_a: assert property ((setup && !pwrite && paddr == ADDR_DIAG && !bank) |=>
    prdata == 32'h0 && ol_snap == '0)
    else $error("diagnosis flags visible with bank deselected");
  ol_restart_a: assert property (!ol_arm[4] |=> !ol_qual[4] ##1 !ol_qual[4])
    else $error("open-load timer did not restart");
  ol_race_a: assert property ((ol_qual_g != '0) |=>
    ((ol_flag & $past(ol_qual_g)) == $past(ol_qual_g)))
    else $error("open-load event lost");

endmodule : cdl_diag

// [design/cdl_ol_timer.sv]
// Open-load qualification timer for one channel, counting microsecond ticks.
`timescale 1ns/1ps
module cdl_ol_timer (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic tick,
  input  wire logic arm,
  output logic      qualified
);
  import cdl_pkg::*;

  cdl_olt_state_t state;
  cdl_olt_state_t next_state;
  logic [7:0]     cnt;
  logic [7:0]     next_cnt;

  ////////////////////////////////////////////////////////////////////////////////
  always_comb begin
    next_state = state;
    next_cnt   = cnt;
    case (state)
      OLT_IDLE: begin
        next_cnt = 8'h00;
        if (arm) begin
          next_state = OLT_COUNT;
        end
      end
      OLT_COUNT: begin
        if (!arm) begin
          next_state = OLT_IDLE;
        end else if (tick) begin
          next_cnt = cnt + 8'h01;
          if (cnt == 8'(OPEN_LOAD_DELAY_TICKS - 1)) begin
            next_state = OLT_HIT;
          end
        end
      end
      OLT_HIT: begin
        if (!arm) begin
          next_state = OLT_IDLE;
        end
      end
      default: begin
        next_state = OLT_IDLE;
      end
    endcase
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state <= OLT_IDLE;
      cnt   <= 8'h00;
    end else begin
      state <= next_state;
      cnt   <= next_cnt;
    end
  end

  assign qualified = (state == OLT_HIT);

endmodule : cdl_ol_timer

// [design/cdl_pkg.sv]
// Shared constants and types of the channel diagnosis latch block.
package cdl_pkg;

  localparam int NUM_CH = 8;

  // Register byte addresses.
  localparam logic [7:0] ADDR_CTRL       = 8'h00;
  localparam logic [7:0] ADDR_CHAN_ON    = 8'h04;
  localparam logic [7:0] ADDR_DIAG_CUR   = 8'h08;
  localparam logic [7:0] ADDR_DIAG       = 8'h0c;
  localparam logic [7:0] ADDR_IRQ_STATUS = 8'h10;
  localparam logic [7:0] ADDR_IRQ_MASK   = 8'h14;
  localparam logic [7:0] ADDR_CHAN_STATE = 8'h18;

  // Field positions.
  localparam int CTRL_CLEAR_BIT = 0;
  localparam int CTRL_BANK_BIT = 1;
  localparam int DIAG_PROT_LSB = 0;
  localparam int DIAG_OL_LSB   = 8;
  localparam int IRQ_PROT_BIT  = 0;
  localparam int IRQ_OL_BIT    = 1;

  // Reset values.
  localparam logic [7:0] CHAN_ON_RST  = 8'h00;
  localparam logic [7:0] DIAG_CUR_RST = 8'h00;
  localparam logic [1:0] IRQ_MASK_RST = 2'h0;

  // Timing.
  localparam int CLK_FREQ_MHZ              = 100;
  localparam int OPEN_LOAD_DELAY_MIN_US    = 100;
  localparam int OPEN_LOAD_DELAY_MAX_US    = 250;
  localparam int OVERLOAD_SHUTOFF_DELAY_US = 60;
  localparam int TICK_CYCLES               = CLK_FREQ_MHZ;
  localparam int OPEN_LOAD_DELAY_TICKS     = OPEN_LOAD_DELAY_MIN_US + 1;
  localparam int OPEN_LOAD_MIN_CYCLES      = OPEN_LOAD_DELAY_MIN_US * CLK_FREQ_MHZ;
  localparam int OPEN_LOAD_MAX_CYCLES      = OPEN_LOAD_DELAY_MAX_US * CLK_FREQ_MHZ;
  localparam int OVERLOAD_SHUTOFF_CYCLES   = OVERLOAD_SHUTOFF_DELAY_US * CLK_FREQ_MHZ;

  typedef logic [NUM_CH-1:0] cdl_chan_t;

  typedef enum logic [1:0] {
    OLT_IDLE  = 2'b00,
    OLT_COUNT = 2'b01,
    OLT_HIT   = 2'b10
  } cdl_olt_state_t;

endpackage : cdl_pkg

// [design/cdl_sync.sv]
// Two flip-flop synchroniser for a vector of asynchronous levels.
`timescale 1ns/1ps
module cdl_sync #(
  parameter int W = 8
) (
  input  wire logic         pclk,
  input  wire logic         presetn,
  input  wire logic [W-1:0] async_in,
  output logic      [W-1:0] sync_out
);

  logic [W-1:0] stage1;

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      stage1   <= '0;
      sync_out <= '0;
    end else begin
      stage1   <= async_in;
      sync_out <= stage1;
    end
  end

endmodule : cdl_sync

// [tb/cdl_diag_test.sv]
// Self-checking bench of the channel diagnosis latch block.
`timescale 1ns/1ps
module cdl_diag_test;
  import cdl_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, irq, e;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  cdl_chan_t   over_temp, over_load, ol_level, chon, dce, sel;
  int          mismatches, compares, cycles, c, k, m_req, m_dc, m_prot;

  cdl_diag u_cdl_diag (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .over_temp_in(over_temp),
    .over_load_in(over_load), .open_load_level_in(ol_level), .channel_on(chon),
    .diag_current_enable(dce), .irq(irq));

  cdl_host u_cdl_host (.pclk(pclk), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  initial begin
    pclk = 1'b0;
    forever #5 pclk = ~pclk;
  end

  task automatic chk(input string n, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      mismatches++;
      $display("mismatch %s expected %h seen %h", n, exp, seen);
    end
  endtask : chk

  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    u_cdl_host.xfer(a, 1'b1, d, q, e);
  endtask : wr

  // Reads and compares data; only addresses past the map may flag an error.
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input string n);
    u_cdl_host.xfer(a, 1'b0, 32'h0, q, e);
    chk(n, q, exp);
    chk("pslverr", {31'h0, e}, {31'h0, a > ADDR_CHAN_STATE});
  endtask : rd

  task automatic print_verdict;
    $display("compares %0d mismatches %0d", compares, mismatches);
    if (mismatches == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : print_verdict

  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      mismatches++;
      print_verdict();
    end
  end

  initial begin
    presetn   = 1'b0;
    over_temp = '0;
    over_load = '0;
    ol_level  = '0;
    c = $urandom(32'h9a1b3340);
    repeat (5) @(posedge pclk);
    presetn <= 1'b1;
    @(posedge pclk);
    rd(ADDR_CHAN_ON, CHAN_ON_RST, "chan_on");
    rd(ADDR_DIAG_CUR, DIAG_CUR_RST, "diag_cur");
    rd(ADDR_IRQ_MASK, IRQ_MASK_RST, "irq_mask");
    rd(8'h1c, 0, "unmapped");
    m_dc = $urandom_range(255, 0);
    wr(ADDR_DIAG_CUR, m_dc);
    chk("diag_current_enable", dce, m_dc);
    rd(ADDR_DIAG_CUR, m_dc, "diag_cur");
    wr(ADDR_IRQ_MASK, 1);
    // Pass 0 over temperature, 1 over load, 2 over temperature while off.
    for (k = 0; k < 3; k++) begin
      c = $urandom_range(7, 0);
      sel = cdl_chan_t'(1 << c);
      m_req = (k == 2) ? (8'hff & ~sel) : 8'hff;
      wr(ADDR_CHAN_ON, m_req);
      over_load <= (k == 1) ? sel : '0;
      over_temp <= (k != 1) ? sel : '0;
      repeat (6) @(posedge pclk);
      m_prot = m_prot | sel;
      chk("channel_on", chon, m_req & ~m_prot);
      chk("irq", irq, 1);
      over_load <= '0;
      over_temp <= '0;
      wr(ADDR_CTRL, 0);
      rd(ADDR_DIAG, 0, "diag_bank0");
      wr(ADDR_CTRL, 2);
      rd(ADDR_DIAG, m_prot, "diag_prot");
      wr(ADDR_CHAN_ON, 8'hff);
      chk("channel_on", chon, 8'hff & ~m_prot);
      rd(ADDR_CHAN_STATE, 8'hff & ~m_prot, "chan_state");
      u_cdl_host.clear_latch(e);
      m_prot = 0;
      chk("channel_on", chon, 8'hff & ~m_prot);
      rd(ADDR_CTRL, 3, "ctrl");
      rd(ADDR_CTRL, 2, "ctrl");
      rd(ADDR_DIAG, m_prot, "diag_prot");
      rd(ADDR_IRQ_STATUS, 1, "irq_status");
      wr(ADDR_IRQ_STATUS, 1);
      @(posedge pclk);
      chk("irq", irq, 0);
    end
    // Channels 0 to 3 on, 4 to 7 off; channel 4 sees a short break.
    wr(ADDR_CHAN_ON, 8'h0f);
    ol_level <= 8'hff;
    repeat (6000) @(posedge pclk);
    ol_level <= 8'hef;
    repeat (2) @(posedge pclk);
    ol_level <= 8'hff;
    repeat (3890) @(posedge pclk);
    rd(ADDR_DIAG, 0, "diag_ol");
    repeat (400) @(posedge pclk);
    rd(ADDR_DIAG, 32'he000, "diag_ol");
    repeat (21000) @(posedge pclk);
    ol_level <= '0;
    repeat (4) @(posedge pclk);
    rd(ADDR_DIAG, 32'hf000, "diag_ol");
    rd(ADDR_DIAG, 0, "diag_ol");
    chk("irq", irq, 0);
    rd(ADDR_IRQ_STATUS, 2, "irq_status");
    wr(ADDR_IRQ_MASK, 3);
    @(posedge pclk);
    chk("irq", irq, 1);
    wr(ADDR_IRQ_STATUS, 2);
    @(posedge pclk);
    chk("irq", irq, 0);
    print_verdict();
  end
endmodule : cdl_diag_test

// [tb/cdl_host.sv]
// Host model that reads and clears diagnosis flags over APB.
`timescale 1ns/1ps
module cdl_host (
  input  wire logic        pclk,
  output logic      [7:0]  paddr,
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic      [31:0] pwdata,
  input  wire logic [31:0] prdata,
  input  wire logic        pready,
  input  wire logic        pslverr
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 8'h00;
    pwdata  = 32'h0;
  end

  // One transfer, held until pready is seen high; a released bus shows inverted address and data, pwrite keeps its value.
  task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] d,
                      output logic [31:0] q, output logic e);
    paddr  <= a;
    pwrite <= w;
    pwdata <= d;
    psel   <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) begin
      @(posedge pclk);
    end
    q = prdata;
    e = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    paddr   <= ~a;
    pwdata  <= ~d;
    @(posedge pclk);
  endtask : xfer

  // clear command sent with the diagnosis bank kept selected.
  task automatic clear_latch(output logic e);
    logic [31:0] q;
    xfer(cdl_pkg::ADDR_CTRL, 1'b1, 32'h3, q, e);
  endtask : clear_latch
endmodule : cdl_host
